// ==== nibble_io_port_with_pin_interrupts_tb_top.sv ====
// self-checking bench for the nibble port block
`timescale 1ns/1ps
module nibble_io_port_with_pin_interrupts_tb_top;
    logic        clock = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, display_enable, irq;
    logic [4:0]  addr = 5'h00;
    logic [3:0]  wdata = 4'h0, rdata, pa_out, pb_out, pc_out, pa_oe, pb_oe, pc_oe;
    logic [3:0]  pa_pullup, pb_pullup, pc_pullup, pd_pullup;
    logic [15:0] low = 16'h0000, pin;
    logic [12:0] irq_vector;
    int          fails = 0, checks = 0;
    always #25 clock = ~clock;
    nio_port dut (.clock, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .pa_in(pin[3:0]), .pb_in(pin[7:4]),
        .pc_in(pin[11:8]), .pd_in(pin[15:12]), .bond_opt(2'h2), .pa_out, .pb_out, .pc_out, .pa_oe, .pb_oe,
        .pc_oe, .pa_pullup, .pb_pullup, .pc_pullup, .pd_pullup, .display_enable, .irq, .irq_vector);
    nio_pins pins (.oe({pc_oe, pb_oe, pa_oe}), .drv({pc_out, pb_out, pa_out}), .low, .pin);
    task automatic final_report;
        if (fails == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, g);
        checks++;
        fails += int'(g !== e);
        if (g !== e) $display("[ERR] %s exp %h got %h", n, e, g);
    endtask
    task automatic wreg(input logic [4:0] a, input logic [3:0] d);
        @(posedge clock) {wr, addr, wdata} <= {1'b1, a, d};
        @(posedge clock) wr <= 1'b0;
    endtask
    task automatic rchk(input logic [4:0] a, input logic [3:0] e);
        @(posedge clock) {rd, addr} <= {1'b1, a};
        @(posedge clock) rd <= 1'b0;
        @(negedge clock) chk("rdata", e, rdata);
    endtask
    task automatic irq_is(input logic [13:0] e);
        repeat (3) @(negedge clock);
        chk("irq", e, {irq, irq_vector});
    endtask
    task automatic s_regs;
        rchk(5'h08, 4'hf);
        wreg(5'h13, 4'h8);
        wreg(5'h08, 4'h5);
        wreg(5'h18, 4'hc);
        rchk(5'h08, 4'h7);
        rchk(5'h13, 4'ha);
        rchk(5'h1b, 4'h0);
        chk("pa_pullup", 16'h0001, pa_pullup);
    endtask
    task automatic s_outs;
        wreg(5'h0b, 4'hf);
        wreg(5'h19, 4'h3);
        wreg(5'h09, 4'h6);
        repeat (2) @(negedge clock);
        chk("pd_pullup", 16'h000f, pd_pullup);
        chk("pb_pullup", 16'h0004, pb_pullup);
        chk("pb_oe", 16'h0003, pb_oe);
        chk("pb_out", 16'h0006, pb_out);
        rchk(5'h0b, 4'hf);
        wreg(5'h1a, 4'hf);
        wreg(5'h0a, 4'h9);
        wreg(5'h13, 4'h4);
        repeat (2) @(negedge clock);
        chk("pc_oe", 16'h000f, pc_oe);
        chk("pc_out", 16'h0009, pc_out);
        chk("display_enable", 16'h0001, display_enable);
        chk("pd_pullup", 16'h0000, pd_pullup);
        chk("pc_pullup", 16'h0000, pc_pullup);
    endtask
    task automatic s_irq;
        wreg(5'h00, 4'h1);
        @(posedge clock) low <= 16'h1000;
        irq_is(14'h0000);
        wreg(5'h1d, 4'h1);
        irq_is(14'h2004);
        @(posedge clock) low <= 16'h0020;
        wreg(5'h01, 4'h0);
        irq_is(14'h2004);
        @(posedge clock) low <= 16'h0001;
        wreg(5'h01, 4'h0);
        irq_is(14'h0000);
        wreg(5'h00, 4'h8);
        irq_is(14'h2001);
    endtask
    initial begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        s_regs();
        s_irq();
        s_outs();
        final_report();
    end
endmodule // nibble_io_port_with_pin_interrupts_tb_top

// ==== nio_defines.vh ====
// register map, field positions, reset values and vectors of the nibble port block
`ifndef NIO_DEFINES_VH
`define NIO_DEFINES_VH
`define NIO_ADDR_IRQ_EN     5'h00
`define NIO_ADDR_IRQ_REQ    5'h01
`define NIO_ADDR_PA_DATA    5'h08
`define NIO_ADDR_PB_DATA    5'h09
`define NIO_ADDR_PC_DATA    5'h0a
`define NIO_ADDR_PD_DATA    5'h0b
`define NIO_ADDR_CTRL       5'h13
`define NIO_ADDR_PA_DIR     5'h18
`define NIO_ADDR_PB_DIR     5'h19
`define NIO_ADDR_PC_DIR     5'h1a
`define NIO_ADDR_RSVD       5'h1b
`define NIO_ADDR_PD_IEN     5'h1d
`define NIO_BIT_PULL_HIGH   3
`define NIO_BIT_DISPLAY     2
`define NIO_BIT_EXT         3
`define NIO_BIT_PORT        0
`define NIO_RESET_NIBBLE    4'h0
`define NIO_VEC_EXT         13'h0001
`define NIO_VEC_PORT        13'h0004
`endif

// ==== nio_pins.sv ====
// board model: pins pulled high by resistors, optional low drivers
`timescale 1ns/1ps
module nio_pins (input wire [11:0] oe, drv, input wire [15:0] low, output wire [15:0] pin);
    assign pin[11:0] = (oe & drv) | (~oe & ~low[11:0]);
    assign pin[15:12] = ~low[15:12];
endmodule // nio_pins

// ==== nio_port.v ====
// nibble i/o ports with pull-high control and low-level pin interrupts
`timescale 1ns/1ps
`include "nio_defines.vh"
module nio_port #(
    parameter W = 4
) (
    input  wire         clock,
    input  wire         rst_n,
    input  wire [4:0]   addr,
    input  wire [3:0]   wdata,
    input  wire         wr,
    input  wire         rd,
    output reg  [3:0]   rdata,
    input  wire [W-1:0] pa_in,
    input  wire [W-1:0] pb_in,
    input  wire [W-1:0] pc_in,
    input  wire [W-1:0] pd_in,
    input  wire [1:0]   bond_opt,
    output reg  [W-1:0] pa_out,
    output reg  [W-1:0] pb_out,
    output reg  [W-1:0] pc_out,
    output reg  [W-1:0] pa_oe,
    output reg  [W-1:0] pb_oe,
    output reg  [W-1:0] pc_oe,
    output reg  [W-1:0] pa_pullup,
    output reg  [W-1:0] pb_pullup,
    output reg  [W-1:0] pc_pullup,
    output reg  [W-1:0] pd_pullup,
    output reg          display_enable,
    output reg          irq,
    output reg  [12:0]  irq_vector
);
    reg [W-1:0] port_a_data;
    reg [W-1:0] port_b_data;
    reg [W-1:0] port_c_data;
    reg [W-1:0] port_a_direction;
    reg [W-1:0] port_b_direction;
    reg [W-1:0] port_c_direction;
    reg [W-1:0] port_d_pin_irq_enable;
    reg         pullhigh_global_enable;
    reg         external_irq_enable;
    reg         port_irq_enable;
    reg         ext_irq_request_flag;
    reg         port_irq_request_flag;
    reg [3:0]   next_rdata;
    wire        ext_low;
    wire        port_low;
    wire        wr_req;
    // input pins read as pin level, output pins as the latch
    wire [W-1:0] pa_view = (pa_in & ~port_a_direction) | (port_a_data & port_a_direction);
    wire [W-1:0] pb_view = (pb_in & ~port_b_direction) | (port_b_data & port_b_direction);
    wire [W-1:0] pc_view = (pc_in & ~port_c_direction) | (port_c_data & port_c_direction);
    reg  [W-1:0] port_d_input_data;

    assign ext_low  = ~port_a_direction[0] & ~pa_in[0];
    assign port_low = |(~port_b_direction & ~pb_in) | |(~port_c_direction & ~pc_in)
                    | |(port_d_pin_irq_enable & ~pd_in);
    assign wr_req   = wr && addr == `NIO_ADDR_IRQ_REQ;

    always @* begin
        next_rdata = 4'h0;
        case (addr)
            `NIO_ADDR_IRQ_EN:  next_rdata = {external_irq_enable, 2'b00, port_irq_enable};
            `NIO_ADDR_IRQ_REQ: next_rdata = {ext_irq_request_flag, 2'b00, port_irq_request_flag};
            `NIO_ADDR_PA_DATA: next_rdata = pa_view;
            `NIO_ADDR_PB_DATA: next_rdata = pb_view;
            `NIO_ADDR_PC_DATA: next_rdata = pc_view;
            `NIO_ADDR_PD_DATA: next_rdata = pd_in;
            `NIO_ADDR_CTRL:    next_rdata = {pullhigh_global_enable, display_enable, bond_opt};
            `NIO_ADDR_PA_DIR:  next_rdata = port_a_direction;
            `NIO_ADDR_PB_DIR:  next_rdata = port_b_direction;
            `NIO_ADDR_PC_DIR:  next_rdata = port_c_direction;
            `NIO_ADDR_PD_IEN:  next_rdata = port_d_pin_irq_enable;
            default:           next_rdata = 4'h0;
        endcase
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            port_a_data            <= `NIO_RESET_NIBBLE;
            port_b_data            <= `NIO_RESET_NIBBLE;
            port_c_data            <= `NIO_RESET_NIBBLE;
            port_d_input_data      <= `NIO_RESET_NIBBLE;
            port_a_direction       <= `NIO_RESET_NIBBLE;
            port_b_direction       <= `NIO_RESET_NIBBLE;
            port_c_direction       <= `NIO_RESET_NIBBLE;
            port_d_pin_irq_enable  <= `NIO_RESET_NIBBLE;
            pullhigh_global_enable <= 1'b0;
            display_enable         <= 1'b0;
            external_irq_enable    <= 1'b0;
            port_irq_enable        <= 1'b0;
            ext_irq_request_flag   <= 1'b0;
            port_irq_request_flag  <= 1'b0;
            rdata                  <= 4'h0;
        end else begin
            rdata <= rd ? next_rdata : 4'h0;
            if (wr) begin
                case (addr)
                    `NIO_ADDR_IRQ_EN: begin
                        external_irq_enable <= wdata[`NIO_BIT_EXT];
                        port_irq_enable     <= wdata[`NIO_BIT_PORT];
                    end
                    `NIO_ADDR_PA_DATA: port_a_data <= wdata;
                    `NIO_ADDR_PB_DATA: port_b_data <= wdata;
                    `NIO_ADDR_PC_DATA: port_c_data <= wdata;
                    `NIO_ADDR_PD_DATA: port_d_input_data <= wdata; // pull-high latch only
                    `NIO_ADDR_CTRL: begin
                        pullhigh_global_enable <= wdata[`NIO_BIT_PULL_HIGH];
                        display_enable         <= wdata[`NIO_BIT_DISPLAY];
                    end
                    `NIO_ADDR_PA_DIR: port_a_direction <= wdata;
                    `NIO_ADDR_PB_DIR: port_b_direction <= wdata;
                    `NIO_ADDR_PC_DIR: port_c_direction <= wdata;
                    `NIO_ADDR_PD_IEN: port_d_pin_irq_enable <= wdata;
                    default: ;
                endcase
            end
            // writing zero clears a request; a pin low in that cycle wins, for the external request only while external_irq_enable is set
            if (ext_low && external_irq_enable)
                ext_irq_request_flag <= 1'b1;
            else if (wr_req && !wdata[`NIO_BIT_EXT])
                ext_irq_request_flag <= 1'b0;
            if (port_low)
                port_irq_request_flag <= 1'b1;
            else if (wr_req && !wdata[`NIO_BIT_PORT])
                port_irq_request_flag <= 1'b0;
        end
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pa_out     <= 4'h0;
            pb_out     <= 4'h0;
            pc_out     <= 4'h0;
            pa_oe      <= 4'h0;
            pb_oe      <= 4'h0;
            pc_oe      <= 4'h0;
            pa_pullup  <= 4'h0;
            pb_pullup  <= 4'h0;
            pc_pullup  <= 4'h0;
            pd_pullup  <= 4'h0;
            irq        <= 1'b0;
            irq_vector <= 13'h0000;
        end else begin
            pa_out    <= port_a_data;
            pb_out    <= port_b_data;
            pc_out    <= port_c_data;
            pa_oe     <= port_a_direction;
            pb_oe     <= port_b_direction;
            pc_oe     <= port_c_direction;
            pa_pullup <= {W{pullhigh_global_enable}} & ~port_a_direction & port_a_data;
            pb_pullup <= {W{pullhigh_global_enable}} & ~port_b_direction & port_b_data;
            pc_pullup <= {W{pullhigh_global_enable}} & ~port_c_direction & port_c_data;
            pd_pullup <= {W{pullhigh_global_enable}} & port_d_input_data;
            irq       <= (ext_irq_request_flag & external_irq_enable)
                       | (port_irq_request_flag & port_irq_enable);
            // external has priority over port
            if (ext_irq_request_flag && external_irq_enable)
                irq_vector <= `NIO_VEC_EXT;
            else if (port_irq_request_flag && port_irq_enable)
                irq_vector <= `NIO_VEC_PORT;
            else
                irq_vector <= 13'h0000;
        end
    end
endmodule // nio_port

// ==== nio_port_sva.sv ====
// checker for the nibble port block
`timescale 1ns/1ps
module nio_port_sva #(parameter W = 4) (input wire clock, rst_n, wr, rd, irq, input wire [4:0] addr,
    input wire [3:0] wdata, rdata, input wire [W-1:0] pa_out, pa_oe, pa_pullup, input wire [12:0] irq_vector);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_rsvd; rd && addr == 5'h1b |=> !rdata; endproperty
    a_rsvd: assert property (p_rsvd) else $error("rsvd read");
    property p_idle; !rd |=> !rdata; endproperty
    a_idle: assert property (p_idle) else $error("stray rdata");
    property p_rst; $rose(rst_n) |-> !(pa_oe | pa_pullup); endproperty
    a_rst: assert property (p_rst) else $error("reset state");
    property p_pull; !(pa_pullup & (pa_oe | ~pa_out)); endproperty
    a_pull: assert property (p_pull) else $error("pull-high");
    property p_dir; wr && addr == 5'h18 |-> ##2 pa_oe == $past(wdata, 2); endproperty
    a_dir: assert property (p_dir) else $error("direction");
    property p_dat; wr && addr == 5'h08 |-> ##2 pa_out == $past(wdata, 2); endproperty
    a_dat: assert property (p_dat) else $error("data latch");
    property p_venc; irq == (irq_vector != 13'h0000); endproperty
    a_venc: assert property (p_venc) else $error("vector vs irq");
    property p_vval; irq_vector inside {13'h0000, 13'h0001, 13'h0004}; endproperty
    a_vval: assert property (p_vval) else $error("vector value");
endmodule // nio_port_sva
bind nio_port nio_port_sva #(.W(W)) u_sva (.clock, .rst_n, .wr, .rd, .irq, .addr, .wdata, .rdata, .pa_out,
    .pa_oe, .pa_pullup, .irq_vector);
